// ### pwm_out_pkg.sv
// Package: register map, field layout and carrier types for the PWM output stage
package pwm_out_pkg;

  // ------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [11:0] OFFS_PAIR_SWAP   = 12'h090;
  localparam logic [11:0] OFFS_OVERRIDE    = 12'h094;
  localparam logic [11:0] OFFS_SYNC_CTRL   = 12'h08C;

  // ------------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------------
  localparam int NUM_CH           = 8;
  localparam int NUM_PAIRS        = 4;
  localparam int SWAP_LSB         = 0;
  localparam int OVR_EN_LSB       = 0;
  localparam int OVR_LVL_LSB      = 8;
  localparam int SYNC_INV_SEL_BIT = 4;
  localparam int SYNC_OVR_SEL_BIT = 5;
  localparam int SYNC_SW_INV_BIT  = 11;
  localparam int SYNC_SW_OVR_BIT  = 12;
  localparam int SYNC_HW_INV_BIT  = 19;
  localparam int SYNC_HW_OVR_BIT  = 20;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [3:0]  SWAP_RESET = 4'h0;
  localparam logic [15:0] OVR_RESET  = 16'h0000;

  // Override register image: levels above enables
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] enable;
  } override_t;

  // Synchronization control bits kept by this block
  typedef struct packed {
    logic hw_ovr;
    logic hw_inv;
    logic sw_ovr;
    logic sw_inv;
    logic ovr_sel;
    logic inv_sel;
  } sync_ctrl_t;

endpackage

// ### pwm_out_stage.sv
// PWM output stage: pair swap and per-channel software override behind APB
// ------------------------------------------------------------------
// How it works
// - With a pair swapped, even pin shows odd output and odd pin even output.
// - Four swap enables in bits 3..0; bit m swaps channel pair m.
// - Swap writes land in a buffer; active swaps load every clock or only on synchronization, per the swap select.
// - Swap bits 31..4 and override bits 31..16 read zero, ignore writes.
// - Override enables in bits 7..0, one per channel.
// - Override levels in bits 15..8; bit 8+n is channel n's forced level.
// - Enabled override drives the channel to its level bit.
// - Disabled override leaves the generated value untouched.
// - Override writes land in a buffer; active fields load every clock or only on synchronization, per the override select.
// - Override register resets to zero: no channel overridden.
// - Override select 0 loads every clock; 1 loads only on a sync event.
// - Swap select 0 loads every clock; 1 loads only on a sync event.
// - Swap sync starts by software trigger or hardware trigger when enabled.
// ------------------------------------------------------------------
//
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
module pwm_out_stage #(
  parameter int NCH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             sw_trigger,
  input  wire logic             hw_trigger,
  input  wire logic [NCH-1:0]   gen_out,
  output logic      [NCH-1:0]   ch_out,
  output logic      [NCH/2-1:0] swap_active,
  output logic      [15:0]      override_active
);

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------
  logic                    wr_en;
  logic                    hit_swap;
  logic                    hit_ovr;
  logic                    hit_sync;
  logic [NCH/2-1:0]        swap_buf_q;
  logic [NCH/2-1:0]        swap_act_q;
  pwm_out_pkg::override_t  ovr_buf_q;
  pwm_out_pkg::override_t  ovr_act_q;
  pwm_out_pkg::sync_ctrl_t sync_q;
  logic                    swap_load;
  logic                    ovr_load;
  logic [NCH-1:0]          swapped;
  logic [NCH-1:0]          ch_out_d;

  assign hit_swap = (paddr == pwm_out_pkg::OFFS_PAIR_SWAP);
  assign hit_ovr  = (paddr == pwm_out_pkg::OFFS_OVERRIDE);
  assign hit_sync = (paddr == pwm_out_pkg::OFFS_SYNC_CTRL);
  assign wr_en    = psel && penable && pwrite;
  // Zero wait states; unmapped addresses answer with an error
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !(hit_swap || hit_ovr || hit_sync);

  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      // Reading returns the buffers, which software wrote last
      if (hit_swap) begin
        prdata[NCH/2-1:0] = swap_buf_q;
      end else if (hit_ovr) begin
        prdata[15:0] = ovr_buf_q;
      end else if (hit_sync) begin
        prdata[pwm_out_pkg::SYNC_INV_SEL_BIT] = sync_q.inv_sel;
        prdata[pwm_out_pkg::SYNC_OVR_SEL_BIT] = sync_q.ovr_sel;
        prdata[pwm_out_pkg::SYNC_SW_INV_BIT]  = sync_q.sw_inv;
        prdata[pwm_out_pkg::SYNC_SW_OVR_BIT]  = sync_q.sw_ovr;
        prdata[pwm_out_pkg::SYNC_HW_INV_BIT]  = sync_q.hw_inv;
        prdata[pwm_out_pkg::SYNC_HW_OVR_BIT]  = sync_q.hw_ovr;
      end
    end
  end

  // ------------------------------------------------------------------
  // Write buffers
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swap_buf_q <= pwm_out_pkg::SWAP_RESET;
    end else if (wr_en && hit_swap) begin
      swap_buf_q <= pwdata[NCH/2-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_buf_q <= pwm_out_pkg::OVR_RESET;
    end else if (wr_en && hit_ovr) begin
      ovr_buf_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q <= '0;
    end else if (wr_en && hit_sync) begin
      sync_q.inv_sel <= pwdata[pwm_out_pkg::SYNC_INV_SEL_BIT];
      sync_q.ovr_sel <= pwdata[pwm_out_pkg::SYNC_OVR_SEL_BIT];
      sync_q.sw_inv  <= pwdata[pwm_out_pkg::SYNC_SW_INV_BIT];
      sync_q.sw_ovr  <= pwdata[pwm_out_pkg::SYNC_SW_OVR_BIT];
      sync_q.hw_inv  <= pwdata[pwm_out_pkg::SYNC_HW_INV_BIT];
      sync_q.hw_ovr  <= pwdata[pwm_out_pkg::SYNC_HW_OVR_BIT];
    end
  end

  // ------------------------------------------------------------------
  // Register synchronization
  // ------------------------------------------------------------------
  // A sync event loads the buffer value present at that edge
  assign swap_load = !sync_q.inv_sel ||
                     (sync_q.sw_inv && sw_trigger) ||
                     (sync_q.hw_inv && hw_trigger);
  assign ovr_load  = !sync_q.ovr_sel ||
                     (sync_q.sw_ovr && sw_trigger) ||
                     (sync_q.hw_ovr && hw_trigger);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swap_act_q <= pwm_out_pkg::SWAP_RESET;
    end else if (swap_load) begin
      swap_act_q <= swap_buf_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_act_q <= pwm_out_pkg::OVR_RESET;
    end else if (ovr_load) begin
      ovr_act_q <= ovr_buf_q;
    end
  end

  assign swap_active     = swap_act_q;
  assign override_active = ovr_act_q;

  // ------------------------------------------------------------------
  // Output path: swap, then override
  // ------------------------------------------------------------------
  for (genvar n = 0; n < NCH; n++) begin : g_ch
    assign swapped[n] = swap_act_q[n/2] ? gen_out[n ^ 1] : gen_out[n];
    // Override wins over the swapped value
    assign ch_out_d[n] = ovr_act_q.enable[n] ? ovr_act_q.level[n] : swapped[n];
  end

  // One register for all pins keeps the mux glitches off the outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch_out <= '0;
    end else begin
      ch_out <= ch_out_d;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  property p_swap_pin;
    @(posedge pclk) disable iff (!presetn)
      (swap_act_q[0] && !ovr_act_q.enable[0]) |=> (ch_out[0] == $past(gen_out[1]));
  endproperty
  a_swap_pin: assert property (p_swap_pin) else $error("swap pin 0 wrong");

  property p_swap_hold;
    @(posedge pclk) disable iff (!presetn)
      (sync_q.inv_sel && !sw_trigger && !hw_trigger) |=> $stable(swap_act_q);
  endproperty
  a_swap_hold: assert property (p_swap_hold) else $error("swap changed without sync");

  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
      (psel && hit_ovr) |-> (prdata[31:16] == 16'h0000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_force;
    @(posedge pclk) disable iff (!presetn)
      ovr_act_q.enable[3] |=> (ch_out[3] == $past(ovr_act_q.level[3]));
  endproperty
  a_force: assert property (p_force) else $error("override level not driven");

  property p_pass;
    @(posedge pclk) disable iff (!presetn)
      (!ovr_act_q.enable[5] && !swap_act_q[2]) |=> (ch_out[5] == $past(gen_out[5]));
  endproperty
  a_pass: assert property (p_pass) else $error("generated value altered");

  property p_ovr_hold;
    @(posedge pclk) disable iff (!presetn)
      (sync_q.ovr_sel && !sw_trigger && !hw_trigger) |=> $stable(ovr_act_q);
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("override changed without sync");

  property p_ovr_follow;
    @(posedge pclk) disable iff (!presetn)
      !sync_q.ovr_sel |=> (ovr_act_q == $past(ovr_buf_q));
  endproperty
  a_ovr_follow: assert property (p_ovr_follow) else $error("override not loaded");

  property p_swap_follow;
    @(posedge pclk) disable iff (!presetn)
      !sync_q.inv_sel |=> (swap_act_q == $past(swap_buf_q));
  endproperty
  a_swap_follow: assert property (p_swap_follow) else $error("swap not loaded");

  property p_sw_sync;
    @(posedge pclk) disable iff (!presetn)
      (sync_q.sw_inv && sw_trigger) |=> (swap_act_q == $past(swap_buf_q));
  endproperty
  a_sw_sync: assert property (p_sw_sync) else $error("sw trigger ignored");

  // ------------------------------------------------------------------
  // Swap path checks
  // ------------------------------------------------------------------
  property p_swap_pin_odd;
    @(posedge pclk) disable iff (!presetn)
      (swap_act_q[0] && !ovr_act_q.enable[1]) |=> (ch_out[1] == $past(gen_out[0]));
  endproperty
  a_swap_pin_odd: assert property (p_swap_pin_odd) else $error("swap pin 1 wrong");

  property p_swap_pair3;
    @(posedge pclk) disable iff (!presetn)
      (swap_act_q[3] && !ovr_act_q.enable[7]) |=> (ch_out[7] == $past(gen_out[6]));
  endproperty
  a_swap_pair3: assert property (p_swap_pair3) else $error("pair 3 swap wrong");

  property p_noswap;
    @(posedge pclk) disable iff (!presetn)
      (!swap_act_q[1] && !ovr_act_q.enable[2]) |=> (ch_out[2] == $past(gen_out[2]));
  endproperty
  a_noswap: assert property (p_noswap) else $error("unswapped pair altered");

  property p_swap_buf_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && hit_swap) |=> (swap_buf_q == $past(pwdata[NCH/2-1:0]));
  endproperty
  a_swap_buf_write: assert property (p_swap_buf_write) else $error("swap buffer write lost");

  property p_swap_buf_hold;
    @(posedge pclk) disable iff (!presetn)
      !(wr_en && hit_swap) |=> $stable(swap_buf_q);
  endproperty
  a_swap_buf_hold: assert property (p_swap_buf_hold) else $error("swap buffer changed");

  property p_rsv_swap;
    @(posedge pclk) disable iff (!presetn)
      (psel && hit_swap) |-> (prdata[31:4] == 28'h0000000);
  endproperty
  a_rsv_swap: assert property (p_rsv_swap) else $error("swap reserved bits set");

  property p_err_no_write;
    @(posedge pclk) disable iff (!presetn)
      (pslverr && pwrite) |=> ($stable(swap_buf_q) && $stable(ovr_buf_q));
  endproperty
  a_err_no_write: assert property (p_err_no_write) else $error("unmapped write landed");

  // ------------------------------------------------------------------
  // Override path checks
  // ------------------------------------------------------------------
  property p_ovr_buf_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && hit_ovr) |=> (ovr_buf_q == $past(pwdata[15:0]));
  endproperty
  a_ovr_buf_write: assert property (p_ovr_buf_write) else $error("override buffer write lost");

  property p_ovr_buf_hold;
    @(posedge pclk) disable iff (!presetn)
      !(wr_en && hit_ovr) |=> $stable(ovr_buf_q);
  endproperty
  a_ovr_buf_hold: assert property (p_ovr_buf_hold) else $error("override buffer changed");

  property p_force_low;
    @(posedge pclk) disable iff (!presetn)
      (ovr_act_q.enable[0] && !ovr_act_q.level[0]) |=> !ch_out[0];
  endproperty
  a_force_low: assert property (p_force_low) else $error("forced low not driven");

  property p_level_ignored;
    @(posedge pclk) disable iff (!presetn)
      (!ovr_act_q.enable[0] && !swap_act_q[0]) |=> (ch_out[0] == $past(gen_out[0]));
  endproperty
  a_level_ignored: assert property (p_level_ignored) else $error("idle level leaked");

  property p_override_wins;
    @(posedge pclk) disable iff (!presetn)
      (ovr_act_q.enable[1] && swap_act_q[0]) |=> (ch_out[1] == $past(ovr_act_q.level[1]));
  endproperty
  a_override_wins: assert property (p_override_wins) else $error("swap beat override");

  // ------------------------------------------------------------------
  // Synchronization checks
  // ------------------------------------------------------------------
  property p_hw_sync;
    @(posedge pclk) disable iff (!presetn)
      (sync_q.hw_inv && hw_trigger) |=> (swap_act_q == $past(swap_buf_q));
  endproperty
  a_hw_sync: assert property (p_hw_sync) else $error("hw trigger ignored");

  property p_ovr_sw_sync;
    @(posedge pclk) disable iff (!presetn)
      (sync_q.sw_ovr && sw_trigger) |=> (ovr_act_q == $past(ovr_buf_q));
  endproperty
  a_ovr_sw_sync: assert property (p_ovr_sw_sync) else $error("override sw sync lost");

  property p_ovr_hw_sync;
    @(posedge pclk) disable iff (!presetn)
      (sync_q.hw_ovr && hw_trigger) |=> (ovr_act_q == $past(ovr_buf_q));
  endproperty
  a_ovr_hw_sync: assert property (p_ovr_hw_sync) else $error("override hw sync lost");

  // Every channel obeys the final mux, not only the sampled ones above
  for (genvar k = 0; k < NCH; k++) begin : g_ch_chk
    property p_ch_forced;
      @(posedge pclk) disable iff (!presetn)
        ovr_act_q.enable[k] |=> (ch_out[k] == $past(ovr_act_q.level[k]));
    endproperty
    a_ch_forced: assert property (p_ch_forced) else $error("forced level missing");

    property p_ch_free;
      @(posedge pclk) disable iff (!presetn)
        !ovr_act_q.enable[k] |=> (ch_out[k] == $past(swapped[k]));
    endproperty
    a_ch_free: assert property (p_ch_free) else $error("unforced channel altered");
  end

  c_swap_used: cover property (@(posedge pclk) disable iff (!presetn) swap_act_q != '0);
  c_ovr_used: cover property (@(posedge pclk) disable iff (!presetn) ovr_act_q.enable != '0);
  c_hw_sync: cover property (@(posedge pclk) disable iff (!presetn)
                             sync_q.hw_inv && hw_trigger);
  c_sw_sync: cover property (@(posedge pclk) disable iff (!presetn)
                             sync_q.sw_ovr && sw_trigger);
  c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pslverr);

endmodule // pwm_out_stage

// ### pwm_pair_invert_and_sw_override_tb.sv
// Testbench: APB sequences checking pair swap, software override and their sync
`timescale 1ns/100ps
module pwm_pair_invert_and_sw_override_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        sw_trigger, hw_trigger, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  gen_out, ch_out;
  logic [3:0]  swap_active;
  logic [15:0] override_active;
  logic [15:0] ovr_tab [4];
  int          n_mismatch, checks;
  localparam logic [11:0] A_SW = pwm_out_pkg::OFFS_PAIR_SWAP;
  localparam logic [11:0] A_OV = pwm_out_pkg::OFFS_OVERRIDE;
  localparam logic [11:0] A_SY = pwm_out_pkg::OFFS_SYNC_CTRL;
  localparam logic [31:0] SEL  = 32'h30;
  pwm_out_stage #(.NCH(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sw_trigger(sw_trigger), .hw_trigger(hw_trigger),
    .gen_out(gen_out), .ch_out(ch_out), .swap_active(swap_active),
    .override_active(override_active));
  // ------------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------------
  always #4 pclk = ~pclk;
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Lets a buffer write reach the active copy and then the registered pins
  task automatic settle();
    repeat (4) @(posedge pclk);
    #1;
  endtask
  task automatic pulse(input logic hw);
    @(posedge pclk);
    if (hw) hw_trigger <= 1'b1; else sw_trigger <= 1'b1;
    @(posedge pclk);
    hw_trigger <= 1'b0; sw_trigger <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
  endtask
  function automatic logic [7:0] exp_out(logic [7:0] g, logic [3:0] s, logic [15:0] o);
    logic [7:0] x;
    x = g;
    for (int m = 0; m < 4; m++) if (s[m]) x[2*m+:2] = {g[2*m], g[2*m+1]};
    return (x & ~o[7:0]) | (o[15:8] & o[7:0]);
  endfunction
  task automatic print_verdict();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; sw_trigger = 1'b0; hw_trigger = 1'b0;
    gen_out = 8'h5A;
    ovr_tab = '{16'hA5F0, 16'hFF00, 16'h00FF, 16'h3C3C};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("override_active", 32'h0, {16'h0, override_active});
    apb(1'b0, A_OV, 32'h0); chk("ovr read", 32'h0, rd);
    apb(1'b1, A_OV, 32'hFFFFFFFF); apb(1'b0, A_OV, 32'h0); chk("ovr rsv", 32'h0000FFFF, rd);
    apb(1'b1, A_SW, 32'hFFFFFFFF); apb(1'b0, A_SW, 32'h0); chk("swap rsv", 32'hF, rd);
    settle();
    chk("swap follow", 32'hF, {28'h0, swap_active});
    chk("ovr follow", 32'hFFFF, {16'h0, override_active});
    chk("ch_out all forced", 32'hFF, {24'h0, ch_out});
    apb(1'b1, A_OV, 32'h0);
    // Each pair alone, then all four, on a pattern where every pair differs
    for (int m = 0; m < 5; m++) begin
      apb(1'b1, A_SW, (m == 4) ? 32'hF : (32'h1 << m));
      settle();
      chk("swap_active", (m == 4) ? 32'hF : (32'h1 << m), {28'h0, swap_active});
      chk("ch_out swap", {24'h0, exp_out(gen_out, (m == 4) ? 4'hF : 4'(4'h1 << m), 16'h0)},
          {24'h0, ch_out});
    end
    @(posedge pclk) gen_out <= 8'h0F;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, A_OV, {16'h0, ovr_tab[i]});
      settle();
      chk("ch_out ovr", {24'h0, exp_out(8'h0F, 4'hF, ovr_tab[i])}, {24'h0, ch_out});
    end
    // Triggered loading: buffers must wait for an enabled trigger
    apb(1'b1, A_SY, SEL | 32'h1800);
    apb(1'b1, A_SW, 32'h5); apb(1'b1, A_OV, 32'h0101);
    settle();
    chk("swap held", 32'hF, {28'h0, swap_active});
    chk("ovr held", 32'h3C3C, {16'h0, override_active});
    apb(1'b0, A_SW, 32'h0); chk("swap buffer", 32'h5, rd);
    pulse(1'b0);
    chk("swap sw sync", 32'h5, {28'h0, swap_active});
    chk("ovr sw sync", 32'h0101, {16'h0, override_active});
    apb(1'b1, A_SY, SEL | 32'h180000);
    apb(1'b1, A_SW, 32'hA); apb(1'b1, A_OV, 32'h0202);
    pulse(1'b0);
    chk("swap sw off", 32'h5, {28'h0, swap_active});
    chk("ovr sw off", 32'h0101, {16'h0, override_active});
    pulse(1'b1);
    chk("swap hw sync", 32'hA, {28'h0, swap_active});
    chk("ovr hw sync", 32'h0202, {16'h0, override_active});
    chk("ch_out synced", {24'h0, exp_out(8'h0F, 4'hA, 16'h0202)}, {24'h0, ch_out});
    apb(1'b0, 12'hFF0, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped err", 32'h1, {31'h0, err});
    print_verdict();
  end
endmodule // pwm_pair_invert_and_sw_override_tb
